// *** hdl/gpabc_pkg.sv ***
`default_nettype none

package gpabc_pkg;

  // geometry
  localparam int unsigned NUM_PORTS = 3;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned ADDR_W    = 8;

  // short i/o addresses sit this far below the data-space offsets
  localparam logic [7:0] IO_OFFSET   = 8'h20;
  localparam logic [5:0] IO_ADDR_MAX = 6'h3f;
  // extended i/o space, reachable by load/store only
  localparam logic [7:0] EXT_IO_BASE = 8'h60;

  // data-space offsets, index 0 = port A, 1 = port B, 2 = port C
  localparam logic [7:0] PIN_LEVEL_OFS [NUM_PORTS] = '{8'h20, 8'h23, 8'h26};
  localparam logic [7:0] DIRECTION_OFS [NUM_PORTS] = '{8'h21, 8'h24, 8'h27};
  localparam logic [7:0] OUT_DATA_OFS  [NUM_PORTS] = '{8'h22, 8'h25, 8'h28};
  // port C input level register is not part of this block
  localparam logic       HAS_PIN_LEVEL [NUM_PORTS] = '{1'h1, 1'h1, 1'h0};

  // values after reset
  localparam logic [7:0] DIRECTION_RST = 8'h00;
  localparam logic [7:0] OUT_DATA_RST  = 8'h00;
  localparam logic [7:0] SYNC_RST      = 8'h00;
  localparam logic [7:0] PULLUP_RST    = 8'h00;
  localparam logic [7:0] RDATA_RST     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // one processor access, held for a single cycle
  typedef struct packed {
    logic       ioSpace;   // 1: short i/o address in addr[5:0]
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } gpabc_req_t;

  // pin-facing outputs of one port
  typedef struct packed {
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    logic [7:0] pullupEn;
  } gpabc_pad_t;

endpackage : gpabc_pkg

`default_nettype wire

// *** hdl/gpabc_ports.sv ***
// Functional notes
// RULE1 - short i/o address equals data offset minus 0x20, range 0x00-0x3f
// RULE2 - extended i/o from 0x60 reachable by load/store only, never short
// RULE3 - port A output data: 8-bit rw at 0x22 (short 0x02), resets zero
// RULE4 - port A direction: 8-bit rw at 0x21 (short 0x01), resets zero
// RULE5 - port A pin level at 0x20 (short 0x00) reads pins, no reset; code resets its synchroniser to 0x00
// RULE6 - port B output data: 8-bit rw at 0x25 (short 0x05), resets zero
// RULE7 - port B direction: 8-bit rw at 0x24 (short 0x04), resets zero
// RULE8 - port B pin level at 0x23 (short 0x03) reads pins, no reset; code resets its synchroniser to 0x00
// RULE9 - port C output data: 8-bit rw at 0x28 (short 0x08), resets zero
// RULE10 - port C direction: 8-bit rw at 0x27 (short 0x07), resets zero
// RULE11 - writing a pin level register toggles outputs, stores nothing
// RULE12 - register bit n belongs to pin n of its port, bits 7:0
// RULE13 - direction 0, output 1 enables pull-up unless global disable set
// RULE14 - toggle write: ones invert output bits, zeros leave them alone
// RULE15 - pin levels pass a two-flop synchroniser before being read
`default_nettype none

module gpabc_ports (
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                ce,
  // processor access
  input  wire gpabc_pkg::gpabc_req_t req,
  output logic [7:0]               rdata,
  output logic                     rvalid,
  // global control from the mcu control register
  input  wire logic                pullupGlobalDisable,
  // port A pins
  input  wire logic [7:0]          portAPinIn,
  output gpabc_pkg::gpabc_pad_t    portAPad,
  // port B pins
  input  wire logic [7:0]          portBPinIn,
  output gpabc_pkg::gpabc_pad_t    portBPad,
  // port C pins
  output gpabc_pkg::gpabc_pad_t    portCPad
);

  localparam int unsigned NP = gpabc_pkg::NUM_PORTS;

  logic [7:0] direction_ff  [NP];
  logic [7:0] outData_ff    [NP];
  logic [7:0] pullupEn_ff   [NP];
  logic [7:0] pinSync1_ff   [NP];
  logic [7:0] pinLevel_ff   [NP];
  logic [7:0] pinIn         [NP];
  logic [7:0] rdata_ff;
  logic       rvalid_ff;

  logic [7:0] dataAddr;
  logic       addrOk;
  logic       wrHit;
  logic       rdHit;
  logic [7:0] nxt_rdata;

  assign pinIn[0] = portAPinIn;
  assign pinIn[1] = portBPinIn;
  assign pinIn[2] = 8'h00;

  // short i/o addresses are rebased onto the data-space map
  always_comb begin
    dataAddr = req.addr;
    addrOk   = 1'h1;
    if (req.ioSpace) begin
      dataAddr = 8'({2'h0, req.addr[5:0]} + gpabc_pkg::IO_OFFSET); // [RULE1]
      // anything above 0x3f is beyond the 64 short locations
      addrOk   = (req.addr <= {2'h0, gpabc_pkg::IO_ADDR_MAX}); // [RULE1]
    end else if (req.addr >= gpabc_pkg::EXT_IO_BASE) begin
      // extended space is decoded elsewhere; nothing of ours lives there
      addrOk   = 1'h0;                                           // [RULE2]
    end
  end

  // a rebased short address never reaches 0x60 and above
  assign wrHit = ce && req.wr && addrOk;                          // [RULE2]
  assign rdHit = ce && req.rd && addrOk;

  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam logic [7:0] DIR_OFS = gpabc_pkg::DIRECTION_OFS[p];
    localparam logic [7:0] OUT_OFS = gpabc_pkg::OUT_DATA_OFS[p];
    localparam logic [7:0] PIN_OFS = gpabc_pkg::PIN_LEVEL_OFS[p];
    localparam logic       HAS_PIN = gpabc_pkg::HAS_PIN_LEVEL[p];

    logic dirWr;
    logic outWr;
    logic pinWr;

    assign dirWr = wrHit && (dataAddr == DIR_OFS);     // [RULE4] [RULE7]
    assign outWr = wrHit && (dataAddr == OUT_OFS);     // [RULE3] [RULE6]
    assign pinWr = wrHit && HAS_PIN && (dataAddr == PIN_OFS);  // [RULE11]

    // direction register, zero after reset so every pin is an input
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        direction_ff[p] <= gpabc_pkg::DIRECTION_RST;  // [RULE4] [RULE7] [RULE10]
      end else if (dirWr) begin
        direction_ff[p] <= req.wdata;                 // [RULE12]
      end
    end

    // output data register; pin level writes only toggle it
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        outData_ff[p] <= gpabc_pkg::OUT_DATA_RST;     // [RULE3] [RULE6] [RULE9]
      end else if (outWr) begin
        outData_ff[p] <= req.wdata;                   // [RULE9] [RULE12]
      end else if (pinWr) begin
        outData_ff[p] <= outData_ff[p] ^ req.wdata;   // [RULE11] [RULE14]
      end
    end

    // pull-up follows one cycle after its causes, kept as a flop for the pad
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pullupEn_ff[p] <= gpabc_pkg::PULLUP_RST;
      end else if (ce) begin
        pullupEn_ff[p] <= ~direction_ff[p] & outData_ff[p]
                          & {8{~pullupGlobalDisable}};  // [RULE13]
      end
    end

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pinSync1_ff[p] <= gpabc_pkg::SYNC_RST;
        pinLevel_ff[p] <= gpabc_pkg::SYNC_RST;
      end else if (ce) begin
        pinSync1_ff[p] <= pinIn[p];                   // [RULE15]
        pinLevel_ff[p] <= pinSync1_ff[p];             // [RULE15]
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = gpabc_pkg::UNMAPPED_READ;
    for (int p = 0; p < NP; p++) begin
      if (dataAddr == gpabc_pkg::DIRECTION_OFS[p]) begin
        nxt_rdata = direction_ff[p];
      end
      if (dataAddr == gpabc_pkg::OUT_DATA_OFS[p]) begin
        nxt_rdata = outData_ff[p];
      end
      if (gpabc_pkg::HAS_PIN_LEVEL[p] &&
          dataAddr == gpabc_pkg::PIN_LEVEL_OFS[p]) begin
        nxt_rdata = pinLevel_ff[p];                   // [RULE5] [RULE8]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff  <= gpabc_pkg::RDATA_RST;
      rvalid_ff <= 1'h0;
    end else if (ce) begin
      rvalid_ff <= rdHit;
      if (rdHit) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign rdata  = rdata_ff;
  assign rvalid = rvalid_ff;

  assign portAPad.pinOut   = outData_ff[0];
  assign portAPad.pinOe    = direction_ff[0];
  assign portAPad.pullupEn = pullupEn_ff[0];
  assign portBPad.pinOut   = outData_ff[1];
  assign portBPad.pinOe    = direction_ff[1];
  assign portBPad.pullupEn = pullupEn_ff[1];
  assign portCPad.pinOut   = outData_ff[2];
  assign portCPad.pinOe    = direction_ff[2];
  assign portCPad.pullupEn = pullupEn_ff[2];

endmodule // gpabc_ports

`default_nettype wire

// *** hdl/dummy_none.sv ***
`default_nettype none
`default_nettype wire

// *** dv/gpabc_pin_model.sv ***
`default_nettype none
module gpabc_pin_model (
  // pads from the device
  input  wire gpabc_pkg::gpabc_pad_t padA,
  input  wire gpabc_pkg::gpabc_pad_t padB,
  // external levels on undriven pins
  input  wire logic [7:0]            extA,
  input  wire logic [7:0]            extB,
  // resolved pin levels
  output logic [7:0]                 port_a_pin_level,
  output logic [7:0]                 port_b_pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up wins over a weak external low on an input pin
  assign port_a_pin_level = (padA.pinOe & padA.pinOut) |
                (~padA.pinOe & (padA.pullupEn | extA));
  assign port_b_pin_level = (padB.pinOe & padB.pinOut) |
                (~padB.pinOe & (padB.pullupEn | extB));
endmodule // gpabc_pin_model
`default_nettype wire

// *** dv/gpabc_ports_asserts.sv ***
`default_nettype none
module gpabc_ports_asserts (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire logic                  ce,
  input wire gpabc_pkg::gpabc_req_t req,
  input wire logic [7:0]            rdata,
  input wire logic                  rvalid,
  input wire logic                  pullupGlobalDisable,
  input wire logic [7:0]            portAPinIn,
  input wire gpabc_pkg::gpabc_pad_t portAPad,
  input wire gpabc_pkg::gpabc_pad_t portBPad,
  input wire gpabc_pkg::gpabc_pad_t portCPad
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_a_out; ce && req.rd && !req.ioSpace && req.addr == 8'h22
    |=> rvalid && rdata == $past(portAPad.pinOut); endproperty
  a_rd_a_out: assert property (p_rd_a_out) else $error("bad A out read");
  property p_wr_a_out; ce && req.wr && req.ioSpace && req.addr == 8'h02
    |=> portAPad.pinOut == $past(req.wdata); endproperty
  a_wr_a_out: assert property (p_wr_a_out) else $error("bad A out write");
  property p_wr_a_dir; ce && req.wr && req.ioSpace && req.addr == 8'h01
    |=> portAPad.pinOe == $past(req.wdata); endproperty
  a_wr_a_dir: assert property (p_wr_a_dir) else $error("bad A dir write");
  property p_tgl_b; ce && req.wr && req.ioSpace && req.addr == 8'h03
    |=> portBPad.pinOut == ($past(portBPad.pinOut) ^ $past(req.wdata)); endproperty
  a_tgl_b: assert property (p_tgl_b) else $error("bad B toggle");
  property p_ext; ce && req.wr && req.addr[7:6] != 2'h0
    |=> $stable(portAPad.pinOut) && $stable(portAPad.pinOe); endproperty
  a_ext: assert property (p_ext) else $error("high address wrote A");
  property p_pull; ce |=> portAPad.pullupEn == (~$past(portAPad.pinOe) &
    $past(portAPad.pinOut) & {8{!$past(pullupGlobalDisable)}}); endproperty
  a_pull: assert property (p_pull) else $error("bad pull-up enable");
  property p_pin_a; $stable(portAPinIn) [*3] ##0 ce && req.rd && req.ioSpace &&
    req.addr == 8'h00 |=> rvalid && rdata == $past(portAPinIn); endproperty
  a_pin_a: assert property (p_pin_a) else $error("bad A pin read");
  property p_rd_b_dir; ce && req.rd && req.ioSpace && req.addr == 8'h04
    |=> rvalid && rdata == $past(portBPad.pinOe); endproperty
  a_rd_b_dir: assert property (p_rd_b_dir) else $error("bad B dir read");
endmodule // gpabc_ports_asserts
bind gpabc_ports gpabc_ports_asserts u_chk (.clk, .rstn, .ce, .req, .rdata,
  .rvalid, .pullupGlobalDisable, .portAPinIn, .portAPad, .portBPad, .portCPad);
`default_nettype wire

// *** dv/test_gpabc_ports.sv ***
`default_nettype none
module test_gpabc_ports;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk, rstn, ce, pgd, rvalid;
  logic [7:0]            rdata, port_a_pin_level, port_b_pin_level, extA, extB;
  gpabc_pkg::gpabc_req_t req;
  gpabc_pkg::gpabc_pad_t padA, padB, padC;
  int                    err_total, checked, cyc;
  logic [7:0]            ofs [6] = '{8'h21, 8'h22, 8'h24, 8'h25, 8'h27, 8'h28};
  gpabc_ports DUT (.clk, .rstn, .ce, .req, .rdata, .rvalid,
    .pullupGlobalDisable(pgd), .portAPinIn(port_a_pin_level), .portAPad(padA),
    .portBPinIn(port_b_pin_level), .portBPad(padB), .portCPad(padC));
  gpabc_pin_model u_pins (.padA, .padB, .extA, .extB, .port_a_pin_level, .port_b_pin_level);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobe stands one cycle, so the request is dropped at the taking edge
  task automatic acc(input logic io, w, input logic [7:0] a, d);
    @(posedge clk) req <= '{io, a, w, ~w, d};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic io, input logic [7:0] a, exp);
    acc(io, 1'b0, a, 8'h00);
    #1 chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  initial begin
    {pgd, req, rstn} = '0;
    ce = 1'h1;
    extA = 8'h08;
    extB = 8'h01;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    foreach (ofs[i]) begin
      rd(1'h0, ofs[i], 8'h00);
    end
    foreach (ofs[i]) begin
      acc(1'h1, 1'h1, ofs[i] - 8'h20, ofs[i] ^ 8'h5a);
    end
    foreach (ofs[i]) rd(1'h1, ofs[i] - 8'h20, ofs[i] ^ 8'h5a);
    chk(padC.pinOe, 8'h7d);
    chk(padC.pinOut, 8'h72);
    chk(padC.pullupEn, 8'h02);
    acc(1'h0, 1'h1, 8'h20, 8'h0f);
    rd(1'h0, 8'h22, 8'h77);
    acc(1'h1, 1'h1, 8'h03, 8'hff);
    rd(1'h1, 8'h05, 8'h80);
    repeat (4) @(posedge clk);
    rd(1'h1, 8'h00, 8'h77);
    rd(1'h0, 8'h23, 8'h81);
    chk(padB.pullupEn, 8'h80);
    @(posedge clk) pgd <= 1'h1;
    repeat (4) @(posedge clk);
    rd(1'h1, 8'h00, 8'h73);
    acc(1'h0, 1'h1, 8'h62, 8'hff);
    acc(1'h1, 1'h1, 8'h42, 8'hff);
    // a read of extended space must not be answered here
    acc(1'h0, 1'h0, 8'h62, 8'h00);
    #1 chk({7'h00, rvalid}, 8'h00);
    // a write while the enable is low must be ignored
    @(posedge clk) ce <= 1'h0;
    acc(1'h1, 1'h1, 8'h02, 8'h00);
    @(posedge clk) ce <= 1'h1;
    rd(1'h0, 8'h22, 8'h77);
    tally_and_finish();
  end
endmodule // test_gpabc_ports
`default_nettype wire
